// >>> src/irs_pkg.sv
// Constants and types for the interrupt entry and reset source block.
// Assumes a byte-addressed AXI4-Lite bus with 32-bit data.
package irs_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_MISC  = 8'h20;
  localparam logic [7:0] IDX_CLOCK_RESET_SUPPLY_REG  = 8'h25;
  localparam logic [7:0] IDX_PFLAG = 8'h26;
  localparam logic [7:0] IDX_PEN   = 8'h27;
  localparam logic [7:0] IDX_STAT  = 8'h28;
  localparam logic [7:0] ADDR_MISC  = 8'(IDX_MISC * 4);
  localparam logic [7:0] ADDR_CLOCK_RESET_SUPPLY_REG  = 8'(IDX_CLOCK_RESET_SUPPLY_REG * 4);
  localparam logic [7:0] ADDR_PFLAG = 8'(IDX_PFLAG * 4);
  localparam logic [7:0] ADDR_PEN   = 8'(IDX_PEN * 4);
  localparam logic [7:0] ADDR_STAT  = 8'(IDX_STAT * 4);
  // Status register fields
  localparam int CLOCK_RESET_SUPPLY_REG_WDG_RF  = 0;
  localparam int CLOCK_RESET_SUPPLY_REG_CSS_D   = 1;
  localparam int CLOCK_RESET_SUPPLY_REG_CSS_IE  = 2;
  localparam int CLOCK_RESET_SUPPLY_REG_LVD_RF  = 4;
  // Control register fields: polarity pairs of the two external lines
  localparam int MISC_POL_A   = 3;
  localparam int MISC_POL_B   = 4;
  localparam int MISC_POL_C   = 6;
  localparam int MISC_POL_D   = 7;
  localparam logic [7:0] MISC_RESET = 8'h00;
  localparam logic [7:0] PEN_RESET  = 8'h00;
  // External sensitivity codes
  localparam logic [1:0] SENS_FALL_LOW = 2'h0;
  localparam logic [1:0] SENS_RISE     = 2'h1;
  localparam logic [1:0] SENS_FALL     = 2'h2;
  localparam logic [1:0] SENS_BOTH     = 2'h3;
  // Vectors, highest priority first
  localparam logic [15:0] VEC_TRAP  = 16'hFFFC;
  localparam logic [15:0] VEC_EI0   = 16'hFFFA;
  localparam logic [15:0] VEC_EI1   = 16'hFFF8;
  localparam logic [15:0] VEC_CSS   = 16'hFFF6;
  localparam logic [15:0] VEC_PERI0 = 16'hFFF4;
  localparam logic [15:0] VEC_STEP  = 16'h0002;
  // Source index of the request vector
  localparam int SRC_EI0   = 0;
  localparam int SRC_EI1   = 1;
  localparam int SRC_CSS   = 2;
  localparam int SRC_PERI0 = 3;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_REQ  = 2'b10
  } irs_state_e;
endpackage

// >>> src/irs_ext_if.sv
// Carrier between the top block and one external line detector.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface irs_ext_if #(parameter int W = 8);
  logic [W-1:0] pins;
  logic [W-1:0] pin_en;
  logic [1:0]   sens;
  logic         clr;
  logic         req;
  modport det (input pins, input pin_en, input sens, input clr,
               output req);
  modport ctl (output pins, output pin_en, output sens, output clr,
               input req);
endinterface // irs_ext_if

// >>> src/irs_ext_det.sv
// Edge/level detector for one external interrupt line.
// Assumes pins are synchronous to aclk.
`timescale 1ns/1ps
module irs_ext_det #(
  parameter int W = 8
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Line
  irs_ext_if.det    ext
);
  typedef struct packed {
    logic prev;
    logic latch;
  } irs_det_s;
  irs_det_s st_reg, st_next;
  logic     anded, rise, fall, edge_hit;

  always_comb begin
    // pins ANDed first; a disabled pin never masks
    anded    = &(ext.pins | ~ext.pin_en);
    rise     = anded & ~st_reg.prev;
    fall     = ~anded & st_reg.prev;
    edge_hit = 1'b0;
    case (ext.sens)
      irs_pkg::SENS_RISE: edge_hit = rise;
      irs_pkg::SENS_FALL: edge_hit = fall;
      irs_pkg::SENS_BOTH: edge_hit = rise | fall;
      default:            edge_hit = fall;
    endcase
    st_next      = st_reg;
    st_next.prev = anded;
    // edge latched, cleared on entry; new edge wins
    if (ext.clr) begin
      st_next.latch = 1'b0;
    end
    if (edge_hit) begin
      st_next.latch = 1'b1;
    end
    if (!aresetn) begin
      st_next = '{prev: 1'b1, latch: 1'b0};
    end
  end

  always_ff @(posedge aclk) begin
    st_reg <= st_next;
  end

  assign ext.req = st_reg.latch |
                   ((ext.sens == irs_pkg::SENS_FALL_LOW) & ~st_reg.prev);
endmodule // irs_ext_det

// >>> src/irs_top.sv
// Interrupt entry, priority and vectoring plus the clock/reset/supply
// status register, reached over AXI4-Lite.
// Assumes the CPU core pushes context and fetches the vector on request.
`timescale 1ns/1ps
module irs_top #(
  parameter int NPERIPH = 8,
  parameter int EXT_W   = 8
) (
  // Clock and reset
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // AXI4-Lite write
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  // Reset cause, held by the reset controller while aresetn is low
  input  wire logic               lvd_reset_cause,
  input  wire logic               wdg_reset_cause,
  // Clock safety
  input  wire logic               safe_clock_active,
  // External lines
  input  wire logic [EXT_W-1:0]   ext_pins_a,
  input  wire logic [EXT_W-1:0]   ext_pins_a_en,
  input  wire logic [EXT_W-1:0]   ext_pins_b,
  input  wire logic [EXT_W-1:0]   ext_pins_b_en,
  // Peripherals
  input  wire logic [NPERIPH-1:0] periph_flag_set,
  input  wire logic [NPERIPH-1:0] periph_assoc_access,
  // CPU core
  input  wire logic               cpu_instr_end,
  input  wire logic               cpu_trap,
  input  wire logic               cpu_entry_ack,
  input  wire logic               cpu_interrupt_return_instr,
  input  wire logic               cpu_set_i,
  input  wire logic               cpu_clr_i,
  input  wire logic               cpu_wait_enter,
  input  wire logic               cpu_halt_enter,
  output logic                    irq_req,
  output logic                    irq_is_trap,
  output logic [15:0]             irq_vector,
  output logic                    cc_i_bit,
  output logic                    wake_wait,
  output logic                    wake_halt,
  output logic [7:0]              misc_control_reg
);
  localparam int NSRC = irs_pkg::SRC_PERI0 + NPERIPH;
  localparam int SW   = $clog2(NSRC);
  localparam int PEN_W = NPERIPH;

  initial begin
    if (NPERIPH < 1 || NPERIPH > 8) begin
      $error("NPERIPH must be 1 to 8");
    end
    if (EXT_W < 1) begin
      $error("EXT_W must be at least 1");
    end
  end

  typedef struct packed {
    logic                 awready;
    logic                 aw_held;
    logic [7:0]           aw_addr;
    logic                 wready;
    logic                 w_held;
    logic [7:0]           w_data;
    logic                 w_lane0;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 arready;
    logic                 rvalid;
    logic [7:0]           rdata;
    logic [1:0]           rresp;
    logic [7:0]           misc;
    logic                 lvd_rf;
    logic                 wdg_rf;
    logic                 css_ie;
    logic                 css_d;
    logic [NPERIPH-1:0]   pflag;
    logic [NPERIPH-1:0]   pen;
    logic [NPERIPH-1:0]   parmed;
    logic                 i_bit;
    irs_pkg::irs_state_e  fsm;
    logic                 req;
    logic                 is_trap;
    logic [SW-1:0]        src;
    logic [15:0]          vec;
    logic                 wake_w;
    logic                 wake_h;
  } irs_regs_s;

  irs_regs_s r_reg, r_next;

  irs_ext_if #(.W(EXT_W)) ei0 ();
  irs_ext_if #(.W(EXT_W)) ei1 ();

  irs_ext_det #(.W(EXT_W)) u_ei0 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ext     (ei0.det)
  );
  irs_ext_det #(.W(EXT_W)) u_ei1 (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ext     (ei1.det)
  );

  // Vector of a source index
  function automatic logic [15:0] src_vector(input logic [SW-1:0] s);
    logic [15:0] v;
    v = irs_pkg::VEC_PERI0;
    if (s == SW'(irs_pkg::SRC_EI0)) begin
      v = irs_pkg::VEC_EI0;
    end else if (s == SW'(irs_pkg::SRC_EI1)) begin
      v = irs_pkg::VEC_EI1;
    end else if (s == SW'(irs_pkg::SRC_CSS)) begin
      v = irs_pkg::VEC_CSS;
    end else begin
      v = 16'(irs_pkg::VEC_PERI0 -
              16'(s - SW'(irs_pkg::SRC_PERI0)) * irs_pkg::VEC_STEP);
    end
    return v;
  endfunction

  logic [NSRC-1:0] src_pend;
  logic            css_req;
  logic            any_pend;
  logic [SW-1:0]   win;
  logic            w_fire, rd_fire;
  logic [7:0]      rd_val;
  logic [1:0]      rd_resp;
  logic            clock_reset_supply_reg_read;
  logic            pflag_read;

  always_comb begin
    css_req = r_reg.css_d & r_reg.css_ie;
    src_pend = {r_reg.pflag & r_reg.pen, css_req, ei1.req, ei0.req};
    any_pend = |src_pend;
    win = '0;
    for (int k = NSRC - 1; k >= 0; k--) begin
      if (src_pend[k]) begin
        win = SW'(k);
      end
    end
  end

  // External detector control
  always_comb begin
    ei0.pins   = ext_pins_a;
    ei0.pin_en = ext_pins_a_en;
    ei0.sens   = {r_reg.misc[irs_pkg::MISC_POL_B],
                  r_reg.misc[irs_pkg::MISC_POL_A]};
    ei1.pins   = ext_pins_b;
    ei1.pin_en = ext_pins_b_en;
    ei1.sens   = {r_reg.misc[irs_pkg::MISC_POL_D],
                  r_reg.misc[irs_pkg::MISC_POL_C]};
    ei0.clr = r_reg.req & cpu_entry_ack & ~r_reg.is_trap &
              (r_reg.src == SW'(irs_pkg::SRC_EI0));
    ei1.clr = r_reg.req & cpu_entry_ack & ~r_reg.is_trap &
              (r_reg.src == SW'(irs_pkg::SRC_EI1));
  end

  // Read decode
  always_comb begin
    rd_val  = 8'h00;
    rd_resp = irs_pkg::RESP_OKAY;
    if (s_axi_araddr == irs_pkg::ADDR_MISC) begin
      rd_val = r_reg.misc;
    end else if (s_axi_araddr == irs_pkg::ADDR_CLOCK_RESET_SUPPLY_REG) begin
      rd_val = 8'h00;
      rd_val[irs_pkg::CLOCK_RESET_SUPPLY_REG_LVD_RF] = r_reg.lvd_rf;
      rd_val[irs_pkg::CLOCK_RESET_SUPPLY_REG_CSS_IE] = r_reg.css_ie;
      rd_val[irs_pkg::CLOCK_RESET_SUPPLY_REG_CSS_D]  = r_reg.css_d;
      rd_val[irs_pkg::CLOCK_RESET_SUPPLY_REG_WDG_RF] = r_reg.wdg_rf;
    end else if (s_axi_araddr == irs_pkg::ADDR_PFLAG) begin
      rd_val = 8'(r_reg.pflag);
    end else if (s_axi_araddr == irs_pkg::ADDR_PEN) begin
      rd_val = 8'(r_reg.pen);
    end else if (s_axi_araddr == irs_pkg::ADDR_STAT) begin
      rd_val = {3'h0, r_reg.req, css_req, ei1.req, ei0.req, r_reg.i_bit};
    end else begin
      rd_resp = irs_pkg::RESP_SLVERR;
    end
  end

  always_comb begin
    rd_fire    = s_axi_arvalid & r_reg.arready;
    w_fire     = r_reg.aw_held & r_reg.w_held & ~r_reg.bvalid;
    clock_reset_supply_reg_read  = rd_fire & (s_axi_araddr == irs_pkg::ADDR_CLOCK_RESET_SUPPLY_REG);
    pflag_read = rd_fire & (s_axi_araddr == irs_pkg::ADDR_PFLAG);
    r_next = r_reg;
    // Write channels taken in either order
    if (s_axi_awvalid & r_reg.awready) begin
      r_next.aw_held = 1'b1;
      r_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid & r_reg.wready) begin
      r_next.w_held  = 1'b1;
      r_next.w_data  = s_axi_wdata[7:0];
      r_next.w_lane0 = s_axi_wstrb[0];
    end
    if (r_reg.bvalid & s_axi_bready) begin
      r_next.bvalid = 1'b0;
    end
    if (w_fire) begin
      r_next.aw_held = 1'b0;
      r_next.w_held  = 1'b0;
      r_next.bvalid  = 1'b1;
      r_next.bresp   = irs_pkg::RESP_OKAY;
      if (r_reg.aw_addr == irs_pkg::ADDR_MISC) begin
        if (r_reg.w_lane0) begin
          r_next.misc = r_reg.w_data;
        end
      end else if (r_reg.aw_addr == irs_pkg::ADDR_CLOCK_RESET_SUPPLY_REG) begin
        if (r_reg.w_lane0) begin
          r_next.css_ie = r_reg.w_data[irs_pkg::CLOCK_RESET_SUPPLY_REG_CSS_IE];
          r_next.lvd_rf = r_reg.lvd_rf &
                          r_reg.w_data[irs_pkg::CLOCK_RESET_SUPPLY_REG_LVD_RF];
          r_next.wdg_rf = r_reg.wdg_rf &
                          r_reg.w_data[irs_pkg::CLOCK_RESET_SUPPLY_REG_WDG_RF];
        end
      end else if (r_reg.aw_addr == irs_pkg::ADDR_PFLAG) begin
        if (r_reg.w_lane0) begin
          // zero write clears; latch and arming dropped
          r_next.pflag  = r_reg.pflag & r_reg.w_data[NPERIPH-1:0];
          r_next.parmed = r_reg.parmed & r_reg.w_data[NPERIPH-1:0];
        end
      end else if (r_reg.aw_addr == irs_pkg::ADDR_PEN) begin
        if (r_reg.w_lane0) begin
          r_next.pen = r_reg.w_data[NPERIPH-1:0];
        end
      end else if (r_reg.aw_addr == irs_pkg::ADDR_STAT) begin
        r_next.bresp = irs_pkg::RESP_OKAY;
      end else begin
        r_next.bresp = irs_pkg::RESP_SLVERR;
      end
    end
    if (rd_fire) begin
      r_next.rvalid = 1'b1;
      r_next.rdata  = rd_val;
      r_next.rresp  = rd_resp;
    end else if (r_reg.rvalid & s_axi_rready) begin
      r_next.rvalid = 1'b0;
    end
    // status read arms, associated access clears
    if (pflag_read) begin
      r_next.parmed = r_reg.pflag;
    end
    r_next.pflag  = r_next.pflag & ~(r_reg.parmed & periph_assoc_access);
    r_next.parmed = r_next.parmed & ~periph_assoc_access;
    // Hardware set wins over every clear
    r_next.pflag = r_next.pflag | periph_flag_set;
    // read clears only after the main oscillator recovered
    if (clock_reset_supply_reg_read & ~safe_clock_active) begin
      r_next.css_d = 1'b0;
    end
    if (safe_clock_active) begin
      r_next.css_d = 1'b1;
    end
    // Global mask: core instructions, then low-power entry forcing
    if (cpu_set_i) begin
      r_next.i_bit = 1'b1;
    end
    if (cpu_clr_i | cpu_wait_enter | cpu_halt_enter) begin
      r_next.i_bit = 1'b0;
    end
    if (cpu_interrupt_return_instr) begin
      r_next.i_bit = 1'b0;
    end
    case (r_reg.fsm)
      irs_pkg::ST_IDLE: begin
        // trap ignores mask; others need it clear
        if (cpu_instr_end & cpu_trap) begin
          r_next.fsm     = irs_pkg::ST_REQ;
          r_next.req     = 1'b1;
          r_next.is_trap = 1'b1;
          r_next.vec     = irs_pkg::VEC_TRAP;
        end else if (cpu_instr_end & any_pend & ~r_reg.i_bit) begin
          r_next.fsm     = irs_pkg::ST_REQ;
          r_next.req     = 1'b1;
          r_next.is_trap = 1'b0;
          r_next.src     = win;
          r_next.vec     = src_vector(win);
        end
      end
      irs_pkg::ST_REQ: begin
        // core has pushed context; mask set on entry
        if (cpu_entry_ack) begin
          r_next.fsm   = irs_pkg::ST_IDLE;
          r_next.req   = 1'b0;
          r_next.i_bit = 1'b1;
        end
      end
      default: begin
        r_next.fsm = irs_pkg::ST_IDLE;
        r_next.req = 1'b0;
      end
    endcase
    // any request wakes wait; only external lines wake halt
    r_next.wake_w = any_pend | (cpu_trap & cpu_instr_end);
    r_next.wake_h = ei0.req | ei1.req;
    r_next.awready = ~r_next.aw_held & ~r_next.bvalid;
    r_next.wready  = ~r_next.w_held & ~r_next.bvalid;
    r_next.arready = ~r_next.rvalid;
    if (!aresetn) begin
      r_next = '0;
      r_next.fsm  = irs_pkg::ST_IDLE;
      // control and enable registers start at zero
      r_next.misc = irs_pkg::MISC_RESET;
      r_next.pen  = PEN_W'(irs_pkg::PEN_RESET);
      // cause flags from the reset source
      r_next.lvd_rf = lvd_reset_cause;
      r_next.wdg_rf = wdg_reset_cause & ~lvd_reset_cause;
    end
  end

  always_ff @(posedge aclk) begin
    r_reg <= r_next;
  end

  assign s_axi_awready    = r_reg.awready;
  assign s_axi_wready     = r_reg.wready;
  assign s_axi_bvalid     = r_reg.bvalid;
  assign s_axi_bresp      = r_reg.bresp;
  assign s_axi_arready    = r_reg.arready;
  assign s_axi_rvalid     = r_reg.rvalid;
  assign s_axi_rdata      = {24'h000000, r_reg.rdata};
  assign s_axi_rresp      = r_reg.rresp;
  assign irq_req          = r_reg.req;
  assign irq_is_trap      = r_reg.is_trap;
  assign irq_vector       = r_reg.vec;
  assign cc_i_bit         = r_reg.i_bit;
  assign wake_wait        = r_reg.wake_w;
  assign wake_halt        = r_reg.wake_h;
  assign misc_control_reg = r_reg.misc;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  AST_TRAP_ENTRY: assert property (
    r_reg.fsm == irs_pkg::ST_IDLE && cpu_instr_end && cpu_trap
    |=> irq_req && irq_is_trap && irq_vector == irs_pkg::VEC_TRAP)
    else $error("trap not requested");
  AST_MASK_HOLDS: assert property (
    $rose(irq_req) && !irq_is_trap |-> !$past(cc_i_bit))
    else $error("maskable entry with mask set");
  AST_ENTRY_MASK: assert property (
    irq_req && cpu_entry_ack && !cpu_clr_i && !cpu_interrupt_return_instr &&
    !cpu_wait_enter && !cpu_halt_enter |=> cc_i_bit && !irq_req)
    else $error("mask not set on entry");
  AST_NO_PREEMPT: assert property (
    cc_i_bit && !cpu_trap && !cpu_clr_i && !cpu_interrupt_return_instr &&
    !cpu_wait_enter && !cpu_halt_enter && !irq_req |=> !irq_req)
    else $error("routine preempted");
  AST_INTERRUPT_RETURN_INSTR_CLEAR: assert property (
    cpu_interrupt_return_instr && !(irq_req && cpu_entry_ack) |=> !cc_i_bit)
    else $error("return left mask set");
  AST_CAUSE_CODE: assert property (
    !(r_reg.lvd_rf && r_reg.wdg_rf))
    else $error("both cause flags set");
  AST_SAFE_HOLD: assert property (
    safe_clock_active |=> r_reg.css_d)
    else $error("safe clock flag lost");
  AST_PRIO_EI0: assert property (
    $rose(irq_req) && !irq_is_trap && $past(ei0.req)
    |-> irq_vector == irs_pkg::VEC_EI0)
    else $error("priority order broken");
  AST_HALT_WAKE: assert property (
    wake_halt |-> $past(ei0.req || ei1.req))
    else $error("halt wake from wrong source");
  AST_CSS_GATE: assert property (
    $rose(irq_req) && irq_vector == irs_pkg::VEC_CSS
    |-> $past(r_reg.css_ie && r_reg.css_d))
    else $error("clock safety not gated");
  AST_PFLAG_SET: assert property (
    periph_flag_set[0] |=> r_reg.pflag[0])
    else $error("peripheral flag set lost");
  COV_TRAP:  cover property ($rose(irq_req) && irq_is_trap);
  COV_EXT:   cover property ($rose(irq_req) && irq_vector == irs_pkg::VEC_EI1);
  COV_CSS:   cover property ($rose(irq_req) && irq_vector == irs_pkg::VEC_CSS);
  COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
endmodule // irs_top

// >>> sim/irs_cpu_model.sv
// CPU core model: instruction ends, trap, entry acknowledge, return.
// Assumes the interrupt block's entry handshake on the same clock.
`timescale 1ns/1ps
module irs_cpu_model (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Bench commands
  input  wire logic        trap_cmd,
  input  wire logic        slow,
  // Entry handshake
  input  wire logic        irq_req,
  input  wire logic [15:0] irq_vector,
  output logic             cpu_instr_end,
  output logic             cpu_trap,
  output logic             cpu_entry_ack,
  output logic             cpu_interrupt_return_instr,
  // Entry log
  output logic [15:0]      last_vec,
  output int               n_entries
);
  logic [1:0] ph;
  logic [3:0] wt;
  logic [3:0] svc;
  logic       tp;
  logic       go;
  // Core stalls on a pending entry, so no boundary while irq_req is up
  assign go = (ph == 2'h3) && !irq_req;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {ph, wt, svc, tp, cpu_instr_end, cpu_trap} <= '0;
      {cpu_entry_ack, cpu_interrupt_return_instr, last_vec} <= '0;
      n_entries <= 0;
    end else begin
      ph            <= ph + 2'h1;
      cpu_instr_end <= go;
      cpu_trap      <= go && (tp || trap_cmd);
      tp            <= (tp || trap_cmd) && !go;
      cpu_entry_ack <= 1'h0;
      wt            <= '0;
      if (irq_req && !cpu_entry_ack) begin
        wt <= wt + 4'h1;
        if (wt == (slow ? 4'h4 : 4'h0)) begin
          cpu_entry_ack <= 1'h1;
          last_vec      <= irq_vector;
          n_entries     <= n_entries + 1;
        end
      end
      // return after a fixed routine length
      svc      <= cpu_entry_ack ? 4'h1 : (svc != 4'h0 ? svc + 4'h1 : svc);
      cpu_interrupt_return_instr <= (svc == 4'hF);
    end
  end
endmodule // irs_cpu_model

// >>> sim/irs_top_bench.sv
// Self-checking bench for the interrupt entry and reset source block.
// Assumes the CPU core model of irs_cpu_model.sv on the entry port.
`timescale 1ns/1ps
module irs_top_bench;
  logic        aclk = 1'h0, aresetn = 1'h0, awvalid = 1'h0, wvalid = 1'h0;
  logic        bready = 1'h0, arvalid = 1'h0, rready = 1'h0, safe = 1'h0;
  logic        lvd = 1'h1, wdg = 1'h1, trap_cmd = 1'h0, slow = 1'h0;
  logic [7:0]  awaddr = '0, araddr = '0, pa = '0, pa_en = '0, pb = 8'hFF;
  logic [7:0]  pb_en = '0, pset = '0, pacc = '0, misc;
  logic        wk_w, wk_h, lt = 1'h0;
  logic [3:0]  lp = 4'h0;
  logic [31:0] wdata = '0;
  logic [3:0]  wstrb = 4'hF;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  logic        awready, wready, bvalid, arready, rvalid;
  logic        instr_end, trap, ack, interrupt_return_instr, irq_req, is_trap, cc_i;
  logic [15:0] vec, last_vec, ev;
  int          n_entries, n_errors = 0, num_checks = 0, cyc = 0, ne = 0;
  integer      seed = 32'hD7AB;
  int          idx;
  always #5 aclk = ~aclk;
  irs_top i_irs_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .lvd_reset_cause(lvd),
    .wdg_reset_cause(wdg), .safe_clock_active(safe), .ext_pins_a(pa),
    .ext_pins_a_en(pa_en), .ext_pins_b(pb), .ext_pins_b_en(pb_en),
    .periph_flag_set(pset), .periph_assoc_access(pacc),
    .cpu_instr_end(instr_end), .cpu_trap(trap), .cpu_entry_ack(ack),
    .cpu_interrupt_return_instr(interrupt_return_instr), .cpu_set_i(lp[0]), .cpu_clr_i(lp[1]),
    .cpu_wait_enter(lp[2]), .cpu_halt_enter(lp[3]), .irq_req(irq_req),
    .irq_is_trap(is_trap), .irq_vector(vec), .cc_i_bit(cc_i),
    .wake_wait(wk_w), .wake_halt(wk_h), .misc_control_reg(misc));
  irs_cpu_model i_irs_cpu_model (.aclk(aclk), .aresetn(aresetn),
    .trap_cmd(trap_cmd), .slow(slow), .irq_req(irq_req), .irq_vector(vec),
    .cpu_instr_end(instr_end), .cpu_trap(trap), .cpu_entry_ack(ack),
    .cpu_interrupt_return_instr(interrupt_return_instr), .last_vec(last_vec), .n_entries(n_entries));
  task automatic chk_reg(string n, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_vec(string n, logic [15:0] e, logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d, logic [1:0] er);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (awvalid || wvalid);
    while (!bvalid) @(posedge aclk);
    bready <= 1'h0;
    chk_reg("bresp", {30'h0, er}, {30'h0, bresp});
    @(posedge aclk);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e, logic [1:0] er);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'h0;
    chk_reg("rdata", {24'h0, e}, rdata);
    chk_reg("rresp", {30'h0, er}, {30'h0, rresp});
    @(posedge aclk);
  endtask
  // Bounded wait for the n-th entry
  task automatic upto(int n);
    for (int k = 0; k < 60 && n_entries < n; k++) @(posedge aclk);
    chk_reg("entries", n, n_entries);
  endtask
  // Long enough for entry plus the whole routine
  task automatic settle(logic [15:0] v);
    repeat (50) @(posedge aclk);
    chk_reg("entries", ne, n_entries);
    chk_vec("vector", v, last_vec);
    chk_reg("mask", '0, {31'h0, cc_i});
  endtask
  task automatic do_reset(logic l, logic w);
    lvd <= l;
    wdg <= w;
    aresetn <= 1'h0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  // Trap flag as shown while the entry request stands
  always @(posedge aclk) begin
    if (irq_req) lt <= is_trap;
  end
  initial begin
    do_reset(1'h1, 1'h1);
    rd(irs_pkg::ADDR_CLOCK_RESET_SUPPLY_REG, 8'h10, irs_pkg::RESP_OKAY);
    rd(irs_pkg::ADDR_MISC, 8'h00, irs_pkg::RESP_OKAY);
    chk_reg("wake", 32'h0, {30'h0, wk_h, wk_w});
    rd(8'h04, 8'h00, irs_pkg::RESP_SLVERR);
    wr(8'h04, 8'h55, irs_pkg::RESP_SLVERR);
    wr(irs_pkg::ADDR_CLOCK_RESET_SUPPLY_REG, 8'h04, irs_pkg::RESP_OKAY);
    safe <= 1'h1;
    repeat (3) @(posedge aclk);
    safe <= 1'h0;
    upto(++ne);
    rd(irs_pkg::ADDR_CLOCK_RESET_SUPPLY_REG, 8'h06, irs_pkg::RESP_OKAY);
    settle(irs_pkg::VEC_CSS);
    rd(irs_pkg::ADDR_CLOCK_RESET_SUPPLY_REG, 8'h04, irs_pkg::RESP_OKAY);
    wr(irs_pkg::ADDR_MISC, 8'h08, irs_pkg::RESP_OKAY);
    wstrb <= 4'h0;
    wr(irs_pkg::ADDR_MISC, 8'hFF, irs_pkg::RESP_OKAY);
    wstrb <= 4'hF;
    rd(irs_pkg::ADDR_MISC, 8'h08, irs_pkg::RESP_OKAY);
    chk_reg("misc pins", 32'h08, {24'h0, misc});
    pa_en <= 8'h03;
    pa <= 8'h01;
    settle(irs_pkg::VEC_CSS);
    pa <= 8'h03;
    ne++;
    settle(irs_pkg::VEC_EI0);
    pb_en <= 8'h01;
    for (int s = 1; s < 4; s++) begin
      wr(irs_pkg::ADDR_MISC, {s[1:0], 6'h08}, irs_pkg::RESP_OKAY);
      pb <= 8'hFE;
      ne += (s != 1);
      settle(s == 1 ? irs_pkg::VEC_EI0 : irs_pkg::VEC_EI1);
      pb <= 8'hFF;
      ne += (s != 2);
      settle(irs_pkg::VEC_EI1);
    end
    pa_en <= 8'h01;
    pa <= '0;
    for (int r = 0; r < 4; r++) begin
      idx = {$random(seed)} % 8;
      slow <= r[0];
      ev = irs_pkg::VEC_PERI0 - 16'(2 * idx);
      wr(irs_pkg::ADDR_PEN, 8'h01 << idx, irs_pkg::RESP_OKAY);
      trap_cmd <= 1'h1;
      @(posedge aclk);
      trap_cmd <= 1'h0;
      repeat (9) @(posedge aclk);
      pa <= 8'h01;
      pset[idx] <= 1'h1;
      @(posedge aclk);
      pa <= '0;
      pset <= '0;
      upto(++ne);
      chk_vec("trap vector", irs_pkg::VEC_TRAP, last_vec);
      repeat (3) @(posedge aclk);
      chk_reg("trap flag", 32'h1, {31'h0, lt});
      chk_reg("wake", 32'h3, {30'h0, wk_h, wk_w});
      upto(++ne);
      chk_vec("first vector", irs_pkg::VEC_EI0, last_vec);
      chk_reg("trap flag", 32'h0, {31'h0, lt});
      upto(++ne);
      wr(irs_pkg::ADDR_PFLAG, 8'h00, irs_pkg::RESP_OKAY);
      settle(ev);
    end
    wr(irs_pkg::ADDR_PEN, 8'h00, irs_pkg::RESP_OKAY);
    pset <= 8'h04;
    @(posedge aclk);
    pset <= '0;
    rd(irs_pkg::ADDR_PFLAG, 8'h04, irs_pkg::RESP_OKAY);
    pacc <= 8'h04;
    @(posedge aclk);
    pacc <= '0;
    wr(irs_pkg::ADDR_PEN, 8'h04, irs_pkg::RESP_OKAY);
    settle(ev);
    for (int k = 1; k < 4; k++) begin
      lp <= 4'h1;
      @(posedge aclk);
      lp <= 4'h1 << k;
      @(posedge aclk);
      chk_reg("mask set", 32'h1, {31'h0, cc_i});
      lp <= 4'h0;
      @(posedge aclk);
      chk_reg("mask clear", 32'h0, {31'h0, cc_i});
    end
    do_reset(1'h0, 1'h1);
    rd(irs_pkg::ADDR_CLOCK_RESET_SUPPLY_REG, 8'h01, irs_pkg::RESP_OKAY);
    rd(irs_pkg::ADDR_MISC, 8'h00, irs_pkg::RESP_OKAY);
    // Low level on line a in the reset sensitivity requests at once
    upto(1);
    chk_vec("level vector", irs_pkg::VEC_EI0, last_vec);
    chk_reg("wake", 32'h3, {30'h0, wk_h, wk_w});
    wrap_up();
  end
endmodule // irs_top_bench
